// file: src/fpc_defs.svh
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH
// Register byte offsets
`define A_CTRL     8'h00
`define A_STATUS   8'h04
`define A_COUNT    8'h08
`define A_CATCH    8'h0c
`define A_MODE     8'h10
`define A_PRESET   8'h14
`define A_CONFIG   8'h18
`define A_FALLBACK 8'h1c
`define A_TH_LOW   8'h20
`define A_TH_HIGH  8'h24
// Count mode codes
`define M_UPDOWN   3'h1
`define M_TWOPHASE 3'h2
`define M_UP       3'h3
`define M_DOWN     3'h4
`define M_FREQ     3'h5
// Fallback codes
`define FB_RESET   2'h0
`define FB_FREEZE  2'h1
// Reset values
`define RST_MODE   3'h0
`define RST_PRESET 32'hffffffff
`define RST_CONFIG 11'h4c0
`define RST_FB     2'h0
`define RST_TH_LOW 32'h00000000
`define RST_TH_HI  32'hffffffff
// Timing
`define CLK_KHZ    100000
`define T_SHORT_MS 100
`define T_LONG_MS  1000
`define SHORT_SCALE 32'h0000000a
`endif

// file: src/fpc_pkg.sv
package fpc_pkg;
  typedef struct packed {
    logic meas_valid_clear;
    logic comm_error;
    logic host_stopped;
    logic done_clear;
    logic reinit_cmd;
    logic count_enable;
  } ctrl_type;
  typedef struct packed {
    logic reflex_b_zone_high;
    logic reflex_b_zone_mid;
    logic reflex_b_zone_low;
    logic reflex_a_zone_high;
    logic reflex_a_zone_mid;
    logic reflex_a_zone_low;
    logic catch_in_enable;
    logic preset_in_enable;
    logic gate_select;
    logic reflex_b_active;
    logic reflex_a_active;
  } cfg_type;
  typedef enum logic {GATE_IDLE, GATE_RUN} gate_state_type;
endpackage : fpc_pkg

// file: src/fast_pulse_counter.sv
`timescale 1ns/100ps
`include "fpc_defs.svh"
module fast_pulse_counter #(
  parameter int unsigned GATE_SHORT_CYC = `T_SHORT_MS * (`CLK_KHZ),
  parameter int unsigned GATE_LONG_CYC  = `T_LONG_MS * (`CLK_KHZ)
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Field inputs
  input  wire logic        pulse_in_a,
  input  wire logic        pulse_in_b,
  input  wire logic        preset_in,
  input  wire logic        catch_in,
  // Reflex outputs
  output logic             reflex_out_a,
  output logic             reflex_out_b
);

  // ----------------------------------------
  // Field input conditioning
  // ----------------------------------------
  logic [3:0] pin_raw;
  logic [2:0] sync_r [4];
  logic [3:0] filt_r;
  logic [3:0] filt_d_r;
  logic [3:0] rise;

  assign pin_raw = {catch_in, preset_in, pulse_in_b, pulse_in_a};
  assign rise    = filt_r & ~filt_d_r;

  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        sync_r[i]   <= 3'h0;
        filt_r[i]   <= 1'b0;
        filt_d_r[i] <= 1'b0;
      end else begin
        sync_r[i]   <= {sync_r[i][1:0], pin_raw[i]};
        if (sync_r[i][2] == sync_r[i][1]) begin
          filt_r[i] <= sync_r[i][2];
        end
        filt_d_r[i] <= filt_r[i];
      end
    end
  end

  // ----------------------------------------
  // Software-visible state
  // ----------------------------------------
  fpc_pkg::ctrl_type ctrl_r;
  fpc_pkg::cfg_type  cfg_r;
  logic [2:0]        count_mode_r;
  logic [1:0]        fallback_mode_r;
  logic [31:0]       preset_value_r;
  logic [31:0]       th_low_pend_r;
  logic [31:0]       th_high_pend_r;
  logic [31:0]       low_threshold_r;
  logic [31:0]       high_threshold_r;
  logic [31:0]       current_count_r;
  logic [31:0]       catch_value_r;
  logic              done_flag_r;
  logic              meas_valid_r;
  logic              dir_down_r;
  logic              wr_pend_r;
  logic [7:0]        wr_addr_r;

  // ----------------------------------------
  // Fallback and effective controls
  // ----------------------------------------
  logic fault;
  logic reinit_eff;
  logic en_eff;
  logic is_freq;

  assign fault      = ctrl_r.host_stopped | ctrl_r.comm_error;
  assign reinit_eff = ctrl_r.reinit_cmd |
                      (fault & (fallback_mode_r == `FB_RESET));
  assign en_eff     = ctrl_r.count_enable &
                      ~(fault & (fallback_mode_r == `FB_FREEZE));
  assign is_freq    = (count_mode_r == `M_FREQ);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic addr_ok;
  assign addr_ok = hsel & htrans[1] & hready;

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0;
    case (a)
      `A_CTRL:     d = {26'h0, ctrl_r};
      `A_STATUS:   d = {27'h0, meas_valid_r,
                        current_count_r >= high_threshold_r,
                        current_count_r >= low_threshold_r,
                        done_flag_r, dir_down_r};
      `A_COUNT:    d = current_count_r;
      `A_CATCH:    d = catch_value_r;
      `A_MODE:     d = {29'h0, count_mode_r};
      `A_PRESET:   d = preset_value_r;
      `A_CONFIG:   d = {21'h0, cfg_r};
      `A_FALLBACK: d = {30'h0, fallback_mode_r};
      `A_TH_LOW:   d = th_low_pend_r;
      `A_TH_HIGH:  d = th_high_pend_r;
      default:     d = 32'h0;
    endcase
    return d;
  endfunction : read_mux

  // Zero wait states keep the master simple
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= addr_ok & hwrite;
      wr_addr_r <= {haddr[7:2], 2'b00};
      if (addr_ok & ~hwrite) begin
        hrdata <= read_mux({haddr[7:2], 2'b00});
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_r          <= '0;
      cfg_r           <= `RST_CONFIG;
      count_mode_r    <= `RST_MODE;
      fallback_mode_r <= `RST_FB;
      preset_value_r  <= `RST_PRESET;
      th_low_pend_r   <= `RST_TH_LOW;
      th_high_pend_r  <= `RST_TH_HI;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        `A_CTRL:     ctrl_r          <= hwdata[5:0];
        `A_MODE:     count_mode_r    <= hwdata[2:0];
        `A_PRESET:   preset_value_r  <= hwdata;
        `A_CONFIG:   cfg_r           <= hwdata[10:0];
        `A_FALLBACK: fallback_mode_r <= hwdata[1:0];
        `A_TH_LOW:   th_low_pend_r   <= hwdata;
        `A_TH_HIGH:  th_high_pend_r  <= hwdata;
        default:     ctrl_r          <= ctrl_r;
      endcase
    end
  end

  // Thresholds only take effect on reinit
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      low_threshold_r  <= `RST_TH_LOW;
      high_threshold_r <= `RST_TH_HI;
    end else if (reinit_eff) begin
      low_threshold_r  <= th_low_pend_r;
      high_threshold_r <= th_high_pend_r;
    end
  end

  // ----------------------------------------
  // Frequency gate
  // ----------------------------------------
  fpc_pkg::gate_state_type gate_st_r;
  logic [31:0] gate_cnt_r;
  logic [31:0] edges_r;
  logic        gate_long_r;
  logic        meas_done;
  logic [31:0] edges_fin;
  logic [31:0] freq_hz;
  logic        gate_go;

  assign gate_go   = is_freq & en_eff & ~reinit_eff;
  assign meas_done = (gate_st_r == fpc_pkg::GATE_RUN) & gate_go &
                     (gate_cnt_r == 32'h1);
  assign edges_fin = edges_r + {31'h0, rise[0]};
  // Short gate scales by ten; long gate is already in Hz
  assign freq_hz   = gate_long_r ? edges_fin :
                     32'(edges_fin * `SHORT_SCALE);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      gate_st_r   <= fpc_pkg::GATE_IDLE;
      gate_cnt_r  <= 32'h0;
      edges_r     <= 32'h0;
      gate_long_r <= 1'b0;
    end else begin
      case (gate_st_r)
        fpc_pkg::GATE_IDLE: begin
          if (gate_go) begin
            gate_st_r   <= fpc_pkg::GATE_RUN;
            gate_long_r <= cfg_r.gate_select;
            gate_cnt_r  <= cfg_r.gate_select ? GATE_LONG_CYC : GATE_SHORT_CYC;
            edges_r     <= 32'h0;
          end
        end
        fpc_pkg::GATE_RUN: begin
          if (!gate_go) begin
            gate_st_r <= fpc_pkg::GATE_IDLE;
          end else if (meas_done) begin
            // Back-to-back gates; new base here and on start from idle
            gate_long_r <= cfg_r.gate_select;
            gate_cnt_r  <= cfg_r.gate_select ? GATE_LONG_CYC : GATE_SHORT_CYC;
            edges_r     <= 32'h0;
          end else begin
            gate_cnt_r <= gate_cnt_r - 32'h1;
            edges_r    <= edges_fin;
          end
        end
        default: gate_st_r <= fpc_pkg::GATE_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Counter core
  // ----------------------------------------
  logic        cnt_edge;
  logic        preset_hit;
  logic        done_evt;
  logic [31:0] cnt_inc;
  logic [31:0] cnt_dec;
  logic        go_down;

  assign cnt_inc    = current_count_r + 32'h1;
  assign cnt_dec    = current_count_r - 32'h1;
  assign preset_hit = rise[2] & cfg_r.preset_in_enable;
  assign cnt_edge   = en_eff & rise[0] & ~is_freq;
  // Up/down: pulse_in_b level picks direction; two-phase: B at A rise
  assign go_down    = filt_r[1];

  always_comb begin
    done_evt = 1'b0;
    if (!reinit_eff && !preset_hit && cnt_edge) begin
      case (count_mode_r)
        `M_UP:     done_evt = (cnt_inc == preset_value_r);
        `M_DOWN:   done_evt = (cnt_dec == 32'h0);
        `M_UPDOWN: done_evt = go_down & (cnt_dec == 32'h0);
        default:   done_evt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      current_count_r <= 32'h0;
      dir_down_r      <= 1'b0;
    end else if (reinit_eff) begin
      case (count_mode_r)
        `M_UP, `M_FREQ: current_count_r <= 32'h0;
        default:        current_count_r <= preset_value_r;
      endcase
    end else if (is_freq) begin
      if (meas_done) begin
        current_count_r <= freq_hz;
      end
    end else if (preset_hit) begin
      current_count_r <= preset_value_r;
    end else if (cnt_edge) begin
      case (count_mode_r)
        `M_UP: begin
          current_count_r <= done_evt ? 32'h0 : cnt_inc;
        end
        `M_DOWN: begin
          current_count_r <= done_evt ? preset_value_r : cnt_dec;
        end
        `M_UPDOWN, `M_TWOPHASE: begin
          current_count_r <= go_down ? cnt_dec : cnt_inc;
          dir_down_r      <= go_down;
        end
        default: current_count_r <= current_count_r;
      endcase
    end
  end

  // Set beats clear on the same edge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      done_flag_r <= 1'b0;
    end else if (done_evt) begin
      done_flag_r <= 1'b1;
    end else if (reinit_eff || ctrl_r.done_clear) begin
      done_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meas_valid_r <= 1'b0;
    end else if (meas_done) begin
      meas_valid_r <= 1'b1;
    end else if ((reinit_eff && is_freq) || ctrl_r.meas_valid_clear) begin
      meas_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      catch_value_r <= 32'h0;
    end else if (rise[3] && cfg_r.catch_in_enable) begin
      catch_value_r <= current_count_r;
    end
  end

  // ----------------------------------------
  // Reflex outputs
  // ----------------------------------------
  function automatic logic zone_level(input logic [31:0] c,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi,
                                      input logic [2:0] z);
    logic r;
    r = z[1];
    if (c < lo) begin
      r = z[0];
    end else if (c > hi) begin
      r = z[2];
    end
    return r;
  endfunction : zone_level

  // Reflex outputs lag the count by one cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reflex_out_a <= 1'b0;
      reflex_out_b <= 1'b0;
    end else begin
      reflex_out_a <= cfg_r.reflex_a_active &
        zone_level(current_count_r, low_threshold_r, high_threshold_r,
                   {cfg_r.reflex_a_zone_high, cfg_r.reflex_a_zone_mid,
                    cfg_r.reflex_a_zone_low});
      reflex_out_b <= cfg_r.reflex_b_active &
        zone_level(current_count_r, low_threshold_r, high_threshold_r,
                   {cfg_r.reflex_b_zone_high, cfg_r.reflex_b_zone_mid,
                    cfg_r.reflex_b_zone_low});
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_hold_disabled;
    !en_eff && !reinit_eff && !is_freq && !preset_hit |=> $stable(current_count_r);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled)
    else $error("count moved while disabled");

  property p_reinit_preset;
    reinit_eff && (count_mode_r == `M_DOWN || count_mode_r == `M_UPDOWN)
      |=> current_count_r == $past(preset_value_r);
  endproperty
  a_reinit_preset: assert property (p_reinit_preset)
    else $error("reinit did not load preset");

  property p_reinit_up;
    reinit_eff && count_mode_r == `M_UP |=> current_count_r == 32'h0 && !done_flag_r;
  endproperty
  a_reinit_up: assert property (p_reinit_up)
    else $error("reinit did not clear up count");

  property p_reinit_freq;
    reinit_eff && is_freq |=> current_count_r == 32'h0 && !meas_valid_r;
  endproperty
  a_reinit_freq: assert property (p_reinit_freq)
    else $error("reinit did not clear frequency state");

  sequence s_meas_end;
    meas_done ##1 meas_valid_r;
  endsequence
  property p_meas_valid;
    meas_done |-> s_meas_end;
  endproperty
  a_meas_valid: assert property (p_meas_valid)
    else $error("meas_valid not set after gate");

  property p_up_wrap;
    done_evt && count_mode_r == `M_UP |=> current_count_r == 32'h0 && done_flag_r;
  endproperty
  a_up_wrap: assert property (p_up_wrap)
    else $error("up count did not wrap at preset");

  property p_down_reload;
    done_evt && count_mode_r == `M_DOWN
      |=> current_count_r == $past(preset_value_r) && done_flag_r;
  endproperty
  a_down_reload: assert property (p_down_reload)
    else $error("down count did not reload");

  property p_reflex_off;
    !cfg_r.reflex_a_active [*2] |-> !reflex_out_a;
  endproperty
  a_reflex_off: assert property (p_reflex_off)
    else $error("inactive reflex output driven");

  property p_catch;
    rise[3] && cfg_r.catch_in_enable |=> catch_value_r == $past(current_count_r);
  endproperty
  a_catch: assert property (p_catch)
    else $error("catch value not captured");

  property p_done_hold;
    done_flag_r && !ctrl_r.done_clear && !reinit_eff |=> done_flag_r;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done flag dropped without clear");

endmodule : fast_pulse_counter

// file: sim/pulse_source.sv
`timescale 1ns/100ps
module pulse_source (
  // Clock
  input  wire logic sys_clk,
  // Field pins
  output logic      pulse_a,
  output logic      pulse_b,
  output logic      preset_pin,
  output logic      catch_pin
);
  // ----------------------------------------
  // Field sensor behaviour
  // ----------------------------------------
  initial begin
    pulse_a = 1'b0;
    pulse_b = 1'b0;
    preset_pin = 1'b0;
    catch_pin = 1'b0;
  end
  // Levels held several clocks, the input filter needs two
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : hold
  task automatic burst(input int n, input int half);
    repeat (n) begin
      hold(half);
      pulse_a <= 1'b1;
      hold(half);
      pulse_a <= 1'b0;
    end
  endtask : burst
  task automatic step(input logic on_b, input logic v);
    if (on_b) begin
      pulse_b <= v;
    end else begin
      pulse_a <= v;
    end
  endtask : step
  // Quadrature: B leads A when running backwards
  task automatic quad(input int n, input logic down);
    repeat (n) begin
      hold(4);
      step(down, 1'b1);
      hold(4);
      step(!down, 1'b1);
      hold(4);
      step(down, 1'b0);
      hold(4);
      step(!down, 1'b0);
    end
  endtask : quad
  // Marker goes to the catch pin, or to the preset pin when on_catch is clear
  task automatic mark(input logic on_catch);
    hold(4);
    catch_pin <= on_catch;
    preset_pin <= !on_catch;
    hold(4);
    catch_pin <= 1'b0;
    preset_pin <= 1'b0;
  endtask : mark
endmodule : pulse_source

// file: sim/fast_pulse_counter_reflex_tb.sv
`timescale 1ns/100ps
`include "fpc_defs.svh"
module fast_pulse_counter_reflex_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        sys_clk;
  logic        reset;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        pa;
  logic        pb;
  logic        pp;
  logic        pc;
  logic        ra;
  logic        rb;
  int          n_mismatch;
  int          comparisons;
  int          seed;
  logic [31:0] rv;
  logic [31:0] pv;
  logic [31:0] lo;
  logic [7:0]  rst_a [7] = '{`A_MODE, `A_PRESET, `A_CONFIG, `A_FALLBACK, `A_TH_LOW,
                             `A_TH_HIGH, `A_COUNT};
  logic [31:0] rst_v [7] = '{32'h0, `RST_PRESET, {21'h0, `RST_CONFIG}, 32'h0,
                             `RST_TH_LOW, `RST_TH_HI, 32'h0};

  assign hready = hreadyout;

  // Short gates keep the frequency runs brief
  fast_pulse_counter #(.GATE_SHORT_CYC(100), .GATE_LONG_CYC(1000)) uut (
    .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pulse_in_a(pa),
    .pulse_in_b(pb), .preset_in(pp), .catch_in(pc), .reflex_out_a(ra),
    .reflex_out_b(rb));

  pulse_source src (.sys_clk(sys_clk), .pulse_a(pa), .pulse_b(pb), .preset_pin(pp),
                    .catch_pin(pc));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    // Slave must always answer OKAY
    if (hreadyout !== 1'b1 || hresp !== 1'b0) begin
      n_mismatch++;
      $display("wrong value at %0t: bus hang or error response", $time);
      summarize();
    end
  endtask : wait_ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rv = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rck(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask : rck
  task automatic restart;
    wr(`A_CTRL, 32'h3);
    wr(`A_CTRL, 32'h1);
  endtask : restart
  task automatic settle;
    repeat (8) @(posedge sys_clk);
  endtask : settle
  function automatic logic reflex(input logic [31:0] c, input logic [31:0] l,
                                  input logic [31:0] h, input logic [2:0] z);
    if (c < l) return z[0];
    if (c <= h) return z[1];
    return z[2];
  endfunction : reflex
  // Hit bits compare in every mode
  function automatic logic [31:0] stat(input logic [31:0] c, input logic [31:0] l,
                                       input logic [31:0] h, input logic dn,
                                       input logic mv);
    return {27'h0, mv, c >= h, c >= l, dn, 1'b0};
  endfunction : stat

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h4b82;
    n_mismatch = 0;
    comparisons = 0;
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    foreach (rst_a[i]) rck(rst_a[i], rst_v[i]);
    wr(8'h3c, $random(seed));
    rck(8'h3c, 32'h0);
    // Single up counting, catch and preset pins left idle
    pv = 32'd3 + ($unsigned($random(seed)) % 4);
    wr(`A_MODE, {29'h0, `M_UP});
    wr(`A_PRESET, pv);
    restart();
    src.burst(int'(pv) - 1, 3);
    settle();
    rck(`A_COUNT, pv - 1);
    wr(`A_CTRL, 32'h0);
    src.burst(2, 3);
    settle();
    rck(`A_COUNT, pv - 1);
    restart();
    rck(`A_COUNT, 32'h0);
    src.burst(int'(pv), 3);
    settle();
    rck(`A_COUNT, 32'h0);
    rck(`A_STATUS, stat(32'h0, `RST_TH_LOW, `RST_TH_HI, 1'b1, 1'b0));
    src.burst(1, 3);
    settle();
    rck(`A_STATUS, stat(32'h1, `RST_TH_LOW, `RST_TH_HI, 1'b1, 1'b0));
    wr(`A_CTRL, 32'h5);
    wr(`A_CTRL, 32'h1);
    rck(`A_STATUS, stat(32'h1, `RST_TH_LOW, `RST_TH_HI, 1'b0, 1'b0));
    // Single down counting, done cleared by reinit
    wr(`A_MODE, {29'h0, `M_DOWN});
    restart();
    rck(`A_COUNT, pv);
    src.burst(int'(pv) - 1, 3);
    settle();
    rck(`A_COUNT, 32'h1);
    src.burst(1, 3);
    settle();
    rck(`A_COUNT, pv);
    rck(`A_STATUS, stat(pv, `RST_TH_LOW, `RST_TH_HI, 1'b1, 1'b0));
    restart();
    rck(`A_STATUS, stat(pv, `RST_TH_LOW, `RST_TH_HI, 1'b0, 1'b0));
    wr(`A_MODE, {29'h0, `M_UPDOWN});
    restart();
    rck(`A_COUNT, pv);
    // Encoder with preset marker and catch
    wr(`A_MODE, {29'h0, `M_TWOPHASE});
    wr(`A_CONFIG, 32'h18);
    restart();
    rck(`A_COUNT, pv);
    src.quad(3, 1'b0);
    settle();
    rck(`A_COUNT, pv + 3);
    src.quad(2, 1'b1);
    settle();
    rck(`A_COUNT, pv + 1);
    src.mark(1'b1);
    settle();
    rck(`A_CATCH, pv + 1);
    src.mark(1'b0);
    settle();
    rck(`A_COUNT, pv);
    wr(`A_CONFIG, 32'h0);
    src.quad(2, 1'b0);
    src.mark(1'b1);
    src.mark(1'b0);
    settle();
    rck(`A_CATCH, pv + 1);
    rck(`A_COUNT, pv + 2);
    // Zones: a active low/high set, b inactive with all zones set
    lo = 32'd2 + ($unsigned($random(seed)) % 3);
    wr(`A_MODE, {29'h0, `M_UP});
    wr(`A_PRESET, 32'h40);
    wr(`A_TH_LOW, lo);
    wr(`A_TH_HIGH, lo + 3);
    wr(`A_CONFIG, 32'h7a1);
    restart();
    for (int i = 0; i < 9; i++) begin
      if (i > 0) src.burst(1, 3);
      settle();
      rck(`A_STATUS, stat(i, lo, lo + 3, 1'b0, 1'b0));
      chk({31'h0, ra}, {31'h0, reflex(i, lo, lo + 3, 3'b101)});
      chk({31'h0, rb}, 32'h0);
    end
    wr(`A_CONFIG, 32'h7a2);
    restart();
    settle();
    chk({30'h0, rb, ra}, 32'h2);
    // Frequency meter on both gates, train period 10 clocks
    wr(`A_MODE, {29'h0, `M_FREQ});
    for (int g = 0; g < 2; g++) begin
      wr(`A_CONFIG, g << 2);
      restart();
      rck(`A_STATUS, stat(32'h0, lo, lo + 3, 1'b0, 1'b0));
      fork
        src.burst(g ? 210 : 30, 5);
        begin
          repeat (g ? 2050 : 250) @(posedge sys_clk);
          bus(1'b0, `A_COUNT, 32'h0);
          chk({31'h0, rv >= 90 && rv <= 110}, 32'h1);
          rck(`A_STATUS, stat(rv, lo, lo + 3, 1'b0, 1'b1));
        end
      join
      wr(`A_CTRL, 32'h20);
      wr(`A_CTRL, 32'h0);
      rck(`A_STATUS, stat(rv, lo, lo + 3, 1'b0, 1'b0));
    end
    // Fallback codes, host stop and link fault
    wr(`A_MODE, {29'h0, `M_UP});
    for (int f = 0; f < 3; f++) begin
      wr(`A_FALLBACK, f);
      restart();
      src.burst(2, 3);
      settle();
      wr(`A_CTRL, (f == 2) ? 32'h11 : 32'h9);
      src.burst(3, 3);
      settle();
      rck(`A_COUNT, (f == 0) ? 32'h0 : (f == 1) ? 32'h2 : 32'h5);
      wr(`A_CTRL, 32'h1);
    end
    summarize();
  end
endmodule : fast_pulse_counter_reflex_tb
